/* File: pss_pkg.sv */
// Package of constants and types for the power supervisor and sleep control
package pss_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_WDOG_TIMEOUT = 8'h08;
	localparam logic [7:0] OFF_WDOG_KICK = 8'h0C;
	localparam logic [7:0] OFF_WAKE_CFG = 8'h10;
	localparam logic [7:0] OFF_ALARM_LO = 8'h14;
	localparam logic [7:0] OFF_ALARM_HI = 8'h18;
	localparam logic [7:0] OFF_RTC_LO = 8'h1C;
	localparam logic [7:0] OFF_RTC_HI = 8'h20;
	localparam logic [7:0] OFF_SLOW_INC = 8'h24;
	localparam logic [7:0] OFF_SLEEP_CFG = 8'h28;
	localparam logic [7:0] OFF_DSM_BASE = 8'h80;
	// Field positions
	localparam int CTRL_SLEEP_BIT = 0;
	localparam int WAKE_PIN_EN_BIT = 0;
	localparam int WAKE_POL_BIT = 1;
	localparam int WAKE_ALARM_EN_BIT = 2;
	localparam int WAKE_SLOW_EN_BIT = 3;
	// Reset values
	localparam logic [15:0] WDOG_TIMEOUT_RST = 16'hFFFF;
	localparam logic [31:0] SLOW_INC_RST = 32'h0000_0280;
	localparam logic [3:0] WAKE_CFG_RST = 4'h0;
	// Timing
	localparam int CLK_HZ = 20_000_000;
	localparam int WDOG_TICK_MS = 1;
	localparam int MS_CYCLES = CLK_HZ / 1000 * WDOG_TICK_MS;
	localparam int SLOW_HZ = 31_250;
	localparam int SLOW_CYCLES = CLK_HZ / SLOW_HZ;
	localparam int SEQ_CYCLES = 4;
	// Deep sleep memory words
	localparam int DSM_WORDS = 32;
	// Power states
	typedef enum logic [2:0] {
		PSS_AWAKE, PSS_DN_CLK, PSS_DN_PWR, PSS_ASLEEP, PSS_UP_PWR, PSS_UP_CLK
	} pss_state_t;
endpackage : pss_pkg

/* File: pss_supply_model.sv */
// Model of the supplies, wake pin and reset pin beside the supervisor
`timescale 1ns/1ns
module pss_supply_model (
	input wire logic clk,
	input wire logic [2:0] good_req,
	input wire logic wake_req,
	output logic [2:0] power_good,
	output logic wake_pin,
	output logic ext_rst_n
);
	// Start with supplies down and the pin idle high
	initial begin
		power_good = 3'h0;
		wake_pin = 1'b1;
	end
	// Levels change only just after a clock edge
	always @(posedge clk) begin
		power_good <= good_req;
		wake_pin <= wake_req;
	end
	// External reset pin left unconnected and pulled high
	assign ext_rst_n = 1'b1;
endmodule : pss_supply_model

/* File: pss_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module pss_sync (
	input wire logic clk,
	input wire logic rstn,
	input wire logic din,
	output logic dout
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic q;
	} pss_sync_st_t;
	pss_sync_st_t st_reg, st_next;

	// Shift and accept a level once stages two and three agree
	always_comb begin
		st_next = st_reg;
		st_next.s1 = din;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		if (st_reg.s2 == st_reg.s3) begin
			st_next.q = st_reg.s3;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign dout = st_reg.q;
endmodule : pss_sync

/* File: pss_top.sv */
// Power supervisor, watchdog, power mode control and real-time counter
`timescale 1ns/1ns
module pss_top (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [2:0] power_good,
	input wire logic ext_rst_n,
	input wire logic wake_pin,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic chip_rst_n,
	output logic asleep,
	output logic [7:0] sleep_cfg
);
	typedef struct packed {
		pss_pkg::pss_state_t state;
		logic [2:0] seq_cnt;
		logic chip_rst;
		logic wdog_cause;
		logic [15:0] wdog_timeout;
		logic [15:0] wdog_cnt;
		logic [14:0] ms_cnt;
		logic [3:0] wake_cfg;
		logic wake_pend;
		logic [63:0] alarm;
		logic [63:0] rtc;
		logic [31:0] slow_inc;
		logic [9:0] slow_cnt;
		logic [7:0] sleep_cfg;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic chip_rst_n;
		logic asleep;
	} pss_st_t;
	pss_st_t st_reg, st_next;

	logic [31:0] dsm_mem [pss_pkg::DSM_WORDS];
	logic [2:0] pg_sync;
	logic ext_rst_sync;
	logic wake_sync;
	logic all_good;
	logic setup;
	logic wr_en;
	logic dsm_hit;
	logic [4:0] dsm_idx;
	logic [31:0] dsm_rd;

	// Synchronise each supply flag, the wake pin and external reset
	for (genvar i = 0; i < 3; i++) begin : g_pg
		pss_sync u_pg (
			.clk(clk),
			.rstn(rstn),
			.din(power_good[i]),
			.dout(pg_sync[i])
		);
	end
	pss_sync u_wake (
		.clk(clk),
		.rstn(rstn),
		.din(wake_pin),
		.dout(wake_sync)
	);
	// Pulled high off chip when unconnected; internal supervisor still works
	pss_sync u_ext (
		.clk(clk),
		.rstn(rstn),
		.din(ext_rst_n),
		.dout(ext_rst_sync)
	);

	assign all_good = &pg_sync;

	// Byte-lane merge for writes
	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// APB decode, access answered one cycle after setup
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pwrite && st_reg.pready;
	assign dsm_hit = paddr[7];
	assign dsm_idx = paddr[6:2];
	assign dsm_rd = dsm_mem[dsm_idx];

	// Deep sleep memory, not touched by any reset
	always_ff @(posedge clk) begin
		if (wr_en && dsm_hit) begin
			dsm_mem[dsm_idx] <= merge(dsm_mem[dsm_idx], pwdata, pstrb);
		end
	end

	// Next-state logic
	always_comb begin
		st_next = st_reg;
		st_next.pready = 1'b0;
		st_next.pslverr = 1'b0;
		// Register reads answered in the access phase
		if (setup) begin
			st_next.pready = 1'b1;
			st_next.prdata = 32'h0000_0000;
			if (dsm_hit) begin
				st_next.prdata = dsm_rd;
			end else begin
				unique case (paddr)
					pss_pkg::OFF_CTRL: st_next.prdata = 32'h0000_0000;
					pss_pkg::OFF_STATUS: st_next.prdata =
						{27'h0, st_reg.state, st_reg.wdog_cause,
						 st_reg.chip_rst};
					pss_pkg::OFF_WDOG_TIMEOUT:
						st_next.prdata = {16'h0, st_reg.wdog_timeout};
					pss_pkg::OFF_WDOG_KICK:
						st_next.prdata = {16'h0, st_reg.wdog_cnt};
					pss_pkg::OFF_WAKE_CFG:
						st_next.prdata = {28'h0, st_reg.wake_cfg};
					pss_pkg::OFF_ALARM_LO: st_next.prdata = st_reg.alarm[31:0];
					pss_pkg::OFF_ALARM_HI: st_next.prdata = st_reg.alarm[63:32];
					pss_pkg::OFF_RTC_LO: st_next.prdata = st_reg.rtc[31:0];
					pss_pkg::OFF_RTC_HI: st_next.prdata = st_reg.rtc[63:32];
					pss_pkg::OFF_SLOW_INC: st_next.prdata = st_reg.slow_inc;
					pss_pkg::OFF_SLEEP_CFG:
						st_next.prdata = {24'h0, st_reg.sleep_cfg};
					default: st_next.pslverr = 1'b1;
				endcase
			end
		end
		// Watchdog counts milliseconds only while awake and out of reset
		if (st_reg.state == pss_pkg::PSS_AWAKE && !st_reg.chip_rst) begin
			if (st_reg.ms_cnt == 15'(pss_pkg::MS_CYCLES - 1)) begin
				st_next.ms_cnt = 15'h0000;
				st_next.wdog_cnt = st_reg.wdog_cnt + 16'h0001;
			end else begin
				st_next.ms_cnt = st_reg.ms_cnt + 15'h0001;
			end
		end
		// Real-time counter, independent of the watchdog
		if (st_reg.state == pss_pkg::PSS_ASLEEP &&
			st_reg.wake_cfg[pss_pkg::WAKE_SLOW_EN_BIT]) begin
			if (st_reg.slow_cnt == 10'(pss_pkg::SLOW_CYCLES - 1)) begin
				st_next.slow_cnt = 10'h000;
				st_next.rtc = st_reg.rtc + {32'h0, st_reg.slow_inc};
			end else begin
				st_next.slow_cnt = st_reg.slow_cnt + 10'h001;
			end
		end else begin
			st_next.slow_cnt = 10'h000;
			st_next.rtc = st_reg.rtc + 64'h1;
		end
		// Register writes
		if (wr_en && !dsm_hit) begin
			unique case (paddr)
				pss_pkg::OFF_CTRL: begin
					if (pwdata[pss_pkg::CTRL_SLEEP_BIT] && pstrb[0] &&
						st_reg.state == pss_pkg::PSS_AWAKE) begin
						st_next.state = pss_pkg::PSS_DN_CLK;
						st_next.seq_cnt = 3'h0;
					end
				end
				pss_pkg::OFF_WDOG_TIMEOUT: st_next.wdog_timeout =
					16'(merge({16'h0, st_reg.wdog_timeout}, pwdata, pstrb));
				pss_pkg::OFF_WDOG_KICK: begin
					st_next.wdog_cnt = 16'h0000;
					st_next.ms_cnt = 15'h0000;
				end
				pss_pkg::OFF_WAKE_CFG:
					if (pstrb[0]) st_next.wake_cfg = pwdata[3:0];
				pss_pkg::OFF_ALARM_LO: st_next.alarm[31:0] =
					merge(st_reg.alarm[31:0], pwdata, pstrb);
				pss_pkg::OFF_ALARM_HI: st_next.alarm[63:32] =
					merge(st_reg.alarm[63:32], pwdata, pstrb);
				pss_pkg::OFF_RTC_LO: st_next.rtc[31:0] =
					merge(st_reg.rtc[31:0], pwdata, pstrb);
				pss_pkg::OFF_RTC_HI: st_next.rtc[63:32] =
					merge(st_reg.rtc[63:32], pwdata, pstrb);
				pss_pkg::OFF_SLOW_INC:
					st_next.slow_inc = merge(st_reg.slow_inc, pwdata, pstrb);
				pss_pkg::OFF_SLEEP_CFG:
					if (pstrb[0]) st_next.sleep_cfg = pwdata[7:0];
				default: ;
			endcase
		end
		// Wake stimuli latch in any non-awake state, served only when asleep
		if (st_reg.state != pss_pkg::PSS_AWAKE &&
			((st_reg.wake_cfg[pss_pkg::WAKE_PIN_EN_BIT] &&
			  wake_sync == st_reg.wake_cfg[pss_pkg::WAKE_POL_BIT]) ||
			 (st_reg.wake_cfg[pss_pkg::WAKE_ALARM_EN_BIT] &&
			  st_reg.rtc >= st_reg.alarm))) begin
			st_next.wake_pend = 1'b1;
		end
		// Power mode sequencer
		unique case (st_reg.state)
			pss_pkg::PSS_AWAKE: st_next.wake_pend = 1'b0;
			pss_pkg::PSS_DN_CLK, pss_pkg::PSS_DN_PWR,
			pss_pkg::PSS_UP_PWR, pss_pkg::PSS_UP_CLK: begin
				st_next.seq_cnt = st_reg.seq_cnt + 3'h1;
				if (st_reg.seq_cnt == 3'(pss_pkg::SEQ_CYCLES - 1)) begin
					st_next.seq_cnt = 3'h0;
					unique case (st_reg.state)
						pss_pkg::PSS_DN_CLK: st_next.state = pss_pkg::PSS_DN_PWR;
						pss_pkg::PSS_DN_PWR: st_next.state = pss_pkg::PSS_ASLEEP;
						pss_pkg::PSS_UP_PWR: st_next.state = pss_pkg::PSS_UP_CLK;
						default: st_next.state = pss_pkg::PSS_AWAKE;
					endcase
				end
			end
			pss_pkg::PSS_ASLEEP: begin
				if (st_reg.wake_pend) begin
					st_next.state = pss_pkg::PSS_UP_PWR;
					st_next.wake_pend = 1'b0;
					st_next.seq_cnt = 3'h0;
				end
			end
			default: st_next.state = pss_pkg::PSS_AWAKE;
		endcase
		// Chip reset sources; release needs all good and no external reset
		st_next.chip_rst = !all_good || !ext_rst_sync;
		if (st_reg.state == pss_pkg::PSS_AWAKE && !st_reg.chip_rst &&
			st_reg.wdog_cnt >= st_reg.wdog_timeout &&
			st_reg.wdog_timeout != 16'h0000) begin
			st_next.chip_rst = 1'b1;
			st_next.wdog_cause = 1'b1;
			st_next.wdog_cnt = 16'h0000;
			st_next.ms_cnt = 15'h0000;
		end
		if (!all_good) begin
			// Power loss is a cold start, wherever the sequencer was
			st_next.state = pss_pkg::PSS_AWAKE;
			st_next.seq_cnt = 3'h0;
			st_next.wdog_cause = 1'b0;
			st_next.wdog_cnt = 16'h0000;
			st_next.ms_cnt = 15'h0000;
			st_next.wdog_timeout = pss_pkg::WDOG_TIMEOUT_RST;
			st_next.wake_cfg = pss_pkg::WAKE_CFG_RST;
			st_next.wake_pend = 1'b0;
			st_next.sleep_cfg = 8'h00;
		end
		// Pin copies kept in flops so the outputs carry no decode logic
		st_next.chip_rst_n = !st_next.chip_rst;
		st_next.asleep = (st_next.state == pss_pkg::PSS_ASLEEP);
	end

	// State register; chip reset asserted from power-up
	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_reg <= '0;
			st_reg.chip_rst <= 1'b1;
			st_reg.wdog_timeout <= pss_pkg::WDOG_TIMEOUT_RST;
			st_reg.slow_inc <= pss_pkg::SLOW_INC_RST;
			st_reg.state <= pss_pkg::PSS_AWAKE;
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata = st_reg.prdata;
	assign pready = st_reg.pready;
	assign pslverr = st_reg.pslverr;
	assign chip_rst_n = st_reg.chip_rst_n;
	assign asleep = st_reg.asleep;
	assign sleep_cfg = st_reg.sleep_cfg;

	// Checks
	wdog_reset_a: assert property (@(posedge clk) disable iff (!rstn)
		(st_reg.state == pss_pkg::PSS_AWAKE && !st_reg.chip_rst &&
		 st_reg.wdog_timeout != 16'h0000 &&
		 st_reg.wdog_cnt >= st_reg.wdog_timeout) |=> st_reg.chip_rst)
		else $error("watchdog timeout gave no reset");
	wdog_frozen_a: assert property (@(posedge clk) disable iff (!rstn)
		(st_reg.state != pss_pkg::PSS_AWAKE && all_good &&
		 st_next.state != pss_pkg::PSS_AWAKE) |=> $stable(st_reg.wdog_cnt))
		else $error("watchdog moved outside awake");
	pg_reset_a: assert property (@(posedge clk) disable iff (!rstn)
		!all_good |=> st_reg.chip_rst && st_reg.state == pss_pkg::PSS_AWAKE)
		else $error("supply loss without reset");
	sleep_start_a: assert property (@(posedge clk) disable iff (!rstn)
		(wr_en && paddr == pss_pkg::OFF_CTRL && pwdata[0] && pstrb[0] &&
		 st_reg.state == pss_pkg::PSS_AWAKE && all_good)
		|=> st_reg.state == pss_pkg::PSS_DN_CLK)
		else $error("sleep request ignored");
	wake_only_asleep_a: assert property (@(posedge clk) disable iff (!rstn)
		(st_reg.state == pss_pkg::PSS_DN_PWR && all_good)
		|=> st_reg.state != pss_pkg::PSS_UP_PWR)
		else $error("wake before asleep");
	wake_held_a: assert property (@(posedge clk) disable iff (!rstn)
		(st_reg.state == pss_pkg::PSS_ASLEEP && st_reg.wake_pend && all_good)
		|=> st_reg.state == pss_pkg::PSS_UP_PWR)
		else $error("pending wake not served");
	seq_steps_a: assert property (@(posedge clk) disable iff (!rstn)
		(st_reg.state == pss_pkg::PSS_DN_CLK && st_reg.seq_cnt == 3'h0 &&
		 all_good)[*1] |=> st_reg.state == pss_pkg::PSS_DN_CLK [*3])
		else $error("sequencing step too short");
	rtc_awake_a: assert property (@(posedge clk) disable iff (!rstn)
		(st_reg.state == pss_pkg::PSS_AWAKE && !wr_en)
		|=> st_reg.rtc == $past(st_reg.rtc) + 64'h1)
		else $error("counter missed awake tick");
	cause_kept_a: assert property (@(posedge clk) disable iff (!rstn)
		(st_reg.wdog_cause && all_good) |=> st_reg.wdog_cause)
		else $error("watchdog cause lost");
	apb_answer_a: assert property (@(posedge clk) disable iff (!rstn)
		(psel && !penable) |=> pready)
		else $error("no APB answer");
	sleep_c: cover property (@(posedge clk) disable iff (!rstn)
		st_reg.state == pss_pkg::PSS_ASLEEP);
	wake_c: cover property (@(posedge clk) disable iff (!rstn)
		st_reg.state == pss_pkg::PSS_UP_CLK ##1
		st_reg.state == pss_pkg::PSS_AWAKE);
	wdog_c: cover property (@(posedge clk) disable iff (!rstn)
		$rose(st_reg.wdog_cause));
endmodule : pss_top

/* File: tb.sv */
// Self-checking testbench for the power supervisor and sleep control
`timescale 1ns/1ns
module tb;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [2:0] good_req = 3'h3;
	logic wake_req = 1'b1;
	logic [2:0] power_good;
	logic wake_pin, ext_rst_n, pready, pslverr, chip_rst_n, asleep, rerr;
	logic [31:0] prdata, rdat;
	logic [7:0] sleep_cfg;
	logic [11:0] seq;
	int num_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	int rst_seen = 0;
	int n;
	always #25 clk = ~clk;
	pss_supply_model far (.clk(clk), .good_req(good_req),
		.wake_req(wake_req), .power_good(power_good),
		.wake_pin(wake_pin), .ext_rst_n(ext_rst_n));
	pss_top uut (.clk(clk), .rstn(rstn), .power_good(power_good),
		.ext_rst_n(ext_rst_n), .wake_pin(wake_pin), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .chip_rst_n(chip_rst_n), .asleep(asleep),
		.sleep_cfg(sleep_cfg));
	// Cycle ceiling and count of chip reset cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (chip_rst_n === 1'b0)
			rst_seen <= rst_seen + 1;
		if (cycles == 90000) begin
			num_errors = num_errors + 1;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run
	task automatic check(input string what, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] m, e,
		input string what);
		apb(1'b0, a, 32'h0);
		check(what, rdat & m, e);
	endtask : rd
	// Wait, bounded, for asleep or chip_rst_n to reach a level
	task automatic wait_on(input bit slp, input logic lvl, input int lim);
		n = 0;
		while ((slp ? asleep : chip_rst_n) !== lvl && n < lim) begin
			@(posedge clk);
			n++;
		end
	endtask : wait_on
	// Poll the state field and shift in each new state seen
	task automatic poll(input logic [2:0] stop);
		logic [2:0] last;
		last = 3'h7;
		seq = 12'h000;
		for (int i = 0; i < 30 && last !== stop; i++) begin
			apb(1'b0, pss_pkg::OFF_STATUS, 32'h0);
			if (rdat[4:2] !== last)
				seq = {seq[8:0], rdat[4:2]};
			last = rdat[4:2];
		end
	endtask : poll
	task automatic t_por();
		repeat (20) @(posedge clk);
		check("chip_rst_n held", chip_rst_n, 1'b0);
		good_req <= 3'h7;
		wait_on(1'b0, 1'b1, 40);
		check("chip_rst_n freed", chip_rst_n, 1'b1);
		rd(pss_pkg::OFF_WDOG_TIMEOUT, 32'hFFFF, 32'hFFFF, "tmo");
		rd(pss_pkg::OFF_SLOW_INC, 32'hFFFF_FFFF, 32'h280, "inc");
		rd(pss_pkg::OFF_STATUS, 32'h1C, 32'h0, "state");
		rd(8'h30, 32'hFFFF_FFFF, 32'h0, "unmapped");
		check("pslverr", rerr, 1'b1);
		apb(1'b0, pss_pkg::OFF_RTC_LO, 32'h0);
		seq = rdat[11:0];
		apb(1'b0, pss_pkg::OFF_RTC_LO, 32'h0);
		check("rtc step", rdat[11:0] - seq, 12'h003);
		$display("test reset and registers done");
	endtask : t_por
	task automatic t_pin();
		wr(pss_pkg::OFF_WDOG_TIMEOUT, 32'h1);
		wr(pss_pkg::OFF_WAKE_CFG, 32'h1);
		wr(pss_pkg::OFF_SLEEP_CFG, 32'h5A);
		wr(pss_pkg::OFF_DSM_BASE + 8'h04, 32'hC3A5_5A3C);
		wr(pss_pkg::OFF_WDOG_KICK, 32'h0);
		rst_seen = 0;
		wr(pss_pkg::OFF_CTRL, 32'h1);
		poll(3'h3);
		check("down states", seq, 12'h053);
		check("sleep_cfg", sleep_cfg, 8'h5A);
		repeat (25000) @(posedge clk);
		check("asleep held", asleep, 1'b1);
		check("wdog frozen", rst_seen, 0);
		wake_req <= 1'b0;
		poll(3'h0);
		check("up states", seq, 12'h728);
		wake_req <= 1'b1;
		rd(pss_pkg::OFF_DSM_BASE + 8'h04, 32'hFFFF_FFFF, 32'hC3A5_5A3C,
			"dsm");
		$display("test pin wake done");
	endtask : t_pin
	task automatic t_wdog();
		wr(pss_pkg::OFF_WDOG_KICK, 32'h0);
		wait_on(1'b0, 1'b0, 20100);
		check("wdog fired", n < 20100, 1'b1);
		wr(pss_pkg::OFF_WDOG_TIMEOUT, 32'h0);
		rd(pss_pkg::OFF_STATUS, 32'h2, 32'h2, "cause");
		good_req <= 3'h6;
		wait_on(1'b0, 1'b0, 20);
		check("brown-out", chip_rst_n, 1'b0);
		good_req <= 3'h7;
		wait_on(1'b0, 1'b1, 40);
		check("recovered", chip_rst_n, 1'b1);
		rd(pss_pkg::OFF_STATUS, 32'h2, 32'h0, "cause gone");
		rd(pss_pkg::OFF_WDOG_TIMEOUT, 32'hFFFF, 32'hFFFF, "tmo");
		$display("test watchdog and brown-out done");
	endtask : t_wdog
	task automatic t_alarm();
		wr(pss_pkg::OFF_SLOW_INC, 32'h500);
		apb(1'b0, pss_pkg::OFF_RTC_HI, 32'h0);
		wr(pss_pkg::OFF_ALARM_HI, rdat);
		apb(1'b0, pss_pkg::OFF_RTC_LO, 32'h0);
		wr(pss_pkg::OFF_ALARM_LO, rdat + 32'h0000_1388);
		wr(pss_pkg::OFF_WAKE_CFG, 32'hC);
		wr(pss_pkg::OFF_CTRL, 32'h1);
		wait_on(1'b1, 1'b1, 100);
		wait_on(1'b1, 1'b0, 4000);
		check("slow wake", n >= 1800 && n <= 3200, 1'b1);
		wr(pss_pkg::OFF_ALARM_HI, 32'h0);
		wr(pss_pkg::OFF_ALARM_LO, 32'h0);
		wr(pss_pkg::OFF_CTRL, 32'h1);
		wait_on(1'b1, 1'b1, 100);
		check("still sleeps", asleep, 1'b1);
		wait_on(1'b1, 1'b0, 100);
		check("kept wake", asleep, 1'b0);
		$display("test alarm wake done");
	endtask : t_alarm
	task automatic t_loss();
		wr(pss_pkg::OFF_WAKE_CFG, 32'h0);
		wr(pss_pkg::OFF_CTRL, 32'h1);
		good_req <= 3'h5;
		wait_on(1'b0, 1'b0, 20);
		check("loss reset", chip_rst_n, 1'b0);
		good_req <= 3'h7;
		wait_on(1'b0, 1'b1, 40);
		rd(pss_pkg::OFF_STATUS, 32'h1C, 32'h0, "cold");
		// Pin enabled with high polarity while the pin idles high
		wr(pss_pkg::OFF_WAKE_CFG, 32'h3);
		wr(pss_pkg::OFF_CTRL, 32'h1);
		wait_on(1'b1, 1'b1, 100);
		check("pol sleeps", asleep, 1'b1);
		wait_on(1'b1, 1'b0, 100);
		check("pol wake", asleep, 1'b0);
		$display("test supply loss done");
	endtask : t_loss
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		t_por();
		t_pin();
		t_wdog();
		t_alarm();
		t_loss();
		complete_run();
	end
endmodule : tb
